// ---- hw/pwm_register_write_unlock.sv ----
`timescale 1ns/1ps
`include "pwm_unlock_params.svh"
module pwm_register_write_unlock
    import pwm_unlock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] oscillator_select_config_word,
    input wire reg_access_type acc,
    output prot_regs_type prot_regs,
    output logic protect_active,
    output logic unlock_granted
);
    // All state of the gate except the key sequence in one register
    gate_state_type state_ff;
    gate_state_type nxt_state;

    // Access decode
    access_kind_type kind_now;
    logic acc_valid;
    logic key_write;
    logic granted;

    // Fuse path
    logic fuse_pin;
    logic fuse_agree;
    logic fuse_ready;
    logic fuse_capture;
    logic fuse_value;
    logic [1:0] fill_next;
    logic [`FUSE_SYNC_STAGES-1:0] sync_next;

    // Protected register path
    logic allow;
    logic [`PROT_REG_COUNT-1:0] prot_write;
    logic [15:0] prot_now [`PROT_REG_COUNT];
    logic [15:0] prot_next [`PROT_REG_COUNT];

    // Reset image: protected, nothing sampled yet
    localparam gate_state_type RESET_STATE = '{
        regs: '0,
        fuse_sync: {`FUSE_SYNC_STAGES{`PROTECT_LOCK_FUSE_DEFAULT}},
        fill_cnt: '0,
        fuse: `PROTECT_LOCK_FUSE_DEFAULT,
        fuse_taken: 1'b0
    };

    // Sort the access on this edge
    function automatic access_kind_type access_kind(
        input reg_access_type access
    );
        access_kind_type kind;
        kind = no_access_kind;
        if (access.wr)
        begin
            unique case (access.sel)
                // Key register
                `SEL_KEY_REG:
                begin
                    kind = key_access_kind;
                end
                // Either protected register
                `SEL_OUTPUT_CFG,
                `SEL_FAULT_CFG:
                begin
                    kind = prot_access_kind;
                end
                // Any other register
                `SEL_OTHER_REG:
                begin
                    kind = other_access_kind;
                end
            endcase
        end
        // A read is never a key or a protected write
        else if (access.rd)
        begin
            kind = other_access_kind;
        end
        return kind;
    endfunction

    // Select code of a protected register
    function automatic logic [1:0] prot_sel(
        input int index
    );
        logic [1:0] code;
        // Unknown index points at no protected register
        code = `SEL_OTHER_REG;
        if (index == `OUTPUT_CFG_IDX)
        begin
            code = `SEL_OUTPUT_CFG;
        end
        else if (index == `FAULT_CFG_IDX)
        begin
            code = `SEL_FAULT_CFG;
        end
        return code;
    endfunction

    // Reads count as accesses, so they break a sequence
    assign kind_now = access_kind(acc);
    assign acc_valid = (kind_now != no_access_kind);
    assign key_write = (kind_now == key_access_kind);

    // Key order and grant live in the sequencer
    unlock_sequencer unlock_sequencer_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .acc_valid(acc_valid),
        .key_write(key_write),
        .key_data(acc.wdata),
        .granted(granted)
    );

    assign fuse_pin = oscillator_select_config_word[`PROTECT_LOCK_FUSE_BIT];

    // Fuse word comes from outside the clock domain
    // Three stages keep a metastable sample away from the lock
    generate
        for (genvar stage = 0; stage < `FUSE_SYNC_STAGES; stage++)
        begin : g_sync
            if (stage == 0)
            begin : g_first
                // First stage samples the pin
                assign sync_next[stage] = fuse_pin;
            end
            else
            begin : g_rest
                // Later stages shift along
                assign sync_next[stage] = state_ff.fuse_sync[stage - 1];
            end
        end
    endgenerate

    // Second and third stage must agree
    assign fuse_agree = (state_ff.fuse_sync[`FUSE_SYNC_STAGES - 2] == state_ff.fuse_sync[`FUSE_SYNC_STAGES - 1]);
    assign fuse_value = state_ff.fuse_sync[`FUSE_SYNC_STAGES - 1];

    // Wait until the chain holds only sampled values
    assign fuse_ready = (state_ff.fill_cnt == `FUSE_SYNC_FILL);
    assign fill_next = 2'(state_ff.fill_cnt + `FUSE_FILL_STEP);

    // Fuse taken once after reset
    // A fuse cannot change while running, so later noise is ignored
    assign fuse_capture = !state_ff.fuse_taken && fuse_ready && fuse_agree;

    // Fuse low bypasses lock
    // Nothing lands before the fuse is known
    assign allow = state_ff.fuse_taken && (!state_ff.fuse || granted);

    // Protected registers as an indexed view
    assign prot_now[`OUTPUT_CFG_IDX] = state_ff.regs.output_cfg;
    assign prot_now[`FAULT_CFG_IDX] = state_ff.regs.fault_cfg;

    generate
        for (genvar idx = 0; idx < `PROT_REG_COUNT; idx++)
        begin : g_prot
            // Write lands only when allowed
            assign prot_write[idx] = allow && (kind_now == prot_access_kind) && (acc.sel == prot_sel(idx));
            assign prot_next[idx] = prot_write[idx] ? acc.wdata : prot_now[idx];
        end
    endgenerate

    always_comb
    begin
        nxt_state = state_ff;

        // Shift the synchroniser every cycle
        nxt_state.fuse_sync = sync_next;

        // Count stages filled since reset
        if (!fuse_ready)
        begin
            nxt_state.fill_cnt = fill_next;
        end

        // Take the fuse once
        if (fuse_capture)
        begin
            nxt_state.fuse = fuse_value;
            nxt_state.fuse_taken = 1'b1;
        end

        // Protected registers take their next value
        nxt_state.regs.output_cfg = prot_next[`OUTPUT_CFG_IDX];
        nxt_state.regs.fault_cfg = prot_next[`FAULT_CFG_IDX];
    end

    // Register the whole state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= RESET_STATE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flip-flops
    assign prot_regs = state_ff.regs;
    assign protect_active = state_ff.fuse;
    // Grant is a registered level in the sequencer
    assign unlock_granted = granted;
endmodule

// ---- hw/pwm_unlock_params.svh ----
`ifndef PWM_UNLOCK_PARAMS_SVH
`define PWM_UNLOCK_PARAMS_SVH
// Key values and fuse position
`define UNLOCK_KEY_FIRST 16'habcd
`define UNLOCK_KEY_SECOND 16'h4321
`define PROTECT_LOCK_FUSE_BIT 6
`define PROTECT_LOCK_FUSE_DEFAULT 1'b1
// Register selects on the access port
`define SEL_KEY_REG 2'h0
`define SEL_OUTPUT_CFG 2'h1
`define SEL_FAULT_CFG 2'h2
`define SEL_OTHER_REG 2'h3
// Protected register indices
`define OUTPUT_CFG_IDX 0
`define FAULT_CFG_IDX 1
`define PROT_REG_COUNT 2
// Fuse synchroniser
`define FUSE_SYNC_STAGES 3
`define FUSE_SYNC_FILL 2'h3
`define FUSE_FILL_STEP 2'h1
`endif

// ---- hw/pwm_unlock_pkg.sv ----
package pwm_unlock_pkg;
    typedef enum logic [1:0] {
        idle_st,
        first_key_st,
        granted_st
    } unlock_state_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [15:0] wdata;
    } reg_access_type;
    typedef struct packed {
        unlock_state_type state;
    } unlock_regs_type;
    typedef struct packed {
        logic [15:0] output_cfg;
        logic [15:0] fault_cfg;
    } prot_regs_type;
    typedef enum logic [1:0] {
        no_access_kind,
        key_access_kind,
        prot_access_kind,
        other_access_kind
    } access_kind_type;
    typedef struct packed {
        prot_regs_type regs;
        logic [2:0] fuse_sync;
        logic [1:0] fill_cnt;
        logic fuse;
        logic fuse_taken;
    } gate_state_type;
endpackage

// ---- hw/unlock_sequencer.sv ----
`timescale 1ns/1ps
`include "pwm_unlock_params.svh"
module unlock_sequencer
    import pwm_unlock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic acc_valid,
    input wire logic key_write,
    input wire logic [15:0] key_data,
    output logic granted
);
    unlock_regs_type state_ff;
    unlock_regs_type nxt_state;
    always_comb
    begin
        nxt_state = state_ff;
        if (acc_valid)
        begin
            nxt_state.state = idle_st;
            unique case (state_ff.state)
                idle_st:
                begin
                    if (key_write && key_data == `UNLOCK_KEY_FIRST)
                    begin
                        nxt_state.state = first_key_st;
                    end
                end
                first_key_st:
                begin
                    if (key_write && key_data == `UNLOCK_KEY_SECOND)
                    begin
                        nxt_state.state = granted_st;
                    end
                    else if (key_write && key_data == `UNLOCK_KEY_FIRST)
                    begin
                        nxt_state.state = first_key_st;
                    end
                end
                granted_st:
                begin
                    if (key_write && key_data == `UNLOCK_KEY_FIRST)
                    begin
                        nxt_state.state = first_key_st;
                    end
                end
                default:
                begin
                    nxt_state.state = idle_st;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= '{state: idle_st};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end
    assign granted = (state_ff.state == granted_st);
endmodule

// ---- testbench/pwm_register_write_unlock_tb_top.sv ----
`timescale 1ns/1ps
module pwm_register_write_unlock_tb_top;
    import pwm_unlock_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] fw = 16'h0;
    reg_access_type acc = '0;
    prot_regs_type pr;
    logic pa, ug;
    logic [15:0] ex [1:2];
    logic [15:0] d;
    int fails = 0, num_checks = 0, cyc = 0, s, m;
    pwm_register_write_unlock pwm_register_write_unlock_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .oscillator_select_config_word(fw), .acc(acc), .prot_regs(pr), .protect_active(pa), .unlock_granted(ug));
    initial forever #4 clk_sys = ~clk_sys;
    task chk(string n, logic [15:0] v, logic [15:0] e);
        num_checks++;
        if (v !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, v);
        end
    endtask
    task stop_test;
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task op(logic w, logic [1:0] a, logic [15:0] v);
        @(posedge clk_sys);
        acc <= '{w, !w, a, v};
    endtask
    task idle;
        @(posedge clk_sys);
        acc <= '0;
        @(posedge clk_sys);
        #1;
    endtask
    task chk_regs;
        chk("output_cfg", pr.output_cfg, ex[1]);
        chk("fault_cfg", pr.fault_cfg, ex[2]);
    endtask
    // Only the clean key pair followed at once by the write lands
    function automatic bit exp_write(int mode);
        return mode == 0;
    endfunction
    task boot(logic lock);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        fw <= 16'($urandom) & 16'hffbf | {9'h0, lock, 6'h0};
        repeat (5) @(posedge clk_sys);
        chk("lock_in_reset", {15'h0, pa}, 16'h1);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        ex = '{16'h0, 16'h0};
        chk("lock", {15'h0, pa}, {15'h0, lock});
        chk_regs;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            stop_test;
        end
    end
    initial
    begin
        void'($urandom(43));
        boot(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            s = 1 + i % 2;
            d = 16'($urandom);
            op(1'b1, 2'(s), d);
            ex[s] = d;
            idle;
            chk_regs;
        end
        boot(1'b1);
        for (int i = 0; i < 16; i++)
        begin
            s = 1 + i % 2;
            m = i % 4;
            d = 16'($urandom);
            // Keys and write back to back
            if (m == 3) op(1'b1, 2'h0, 16'h4321);
            if (m != 1) op(1'b1, 2'h0, 16'habcd);
            if (m == 2) op(1'b0, 2'h3, d);
            if (m == 0 || m == 2) op(1'b1, 2'h0, 16'h4321);
            op(1'b1, 2'(s), d);
            if (m == 0) op(1'b1, 2'(s), ~d);
            if (exp_write(m)) ex[s] = d;
            idle;
            chk_regs;
        end
        // Repeated first key restarts; grant waits through idle cycles
        op(1'b1, 2'h0, 16'habcd);
        op(1'b1, 2'h0, 16'habcd);
        op(1'b1, 2'h0, 16'h4321);
        idle;
        chk("granted", {15'h0, ug}, 16'h1);
        d = 16'($urandom);
        op(1'b1, 2'h2, d);
        ex[2] = d;
        idle;
        chk("granted_used", {15'h0, ug}, 16'h0);
        chk_regs;
        // A read between key and write forfeits the unlock
        op(1'b1, 2'h0, 16'habcd);
        op(1'b1, 2'h0, 16'h4321);
        op(1'b0, 2'h1, d);
        op(1'b1, 2'h1, ~d);
        idle;
        chk_regs;
        stop_test;
    end
endmodule

// ---- testbench/pwm_unlock_sva.sv ----
`timescale 1ns/1ps
module pwm_unlock_sva
    import pwm_unlock_pkg::*;
(
    input logic clk_sys,
    input logic rst_n,
    input logic [15:0] oscillator_select_config_word,
    input reg_access_type acc,
    input prot_regs_type prot_regs,
    input logic protect_active,
    input logic unlock_granted
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire k0 = acc.wr && acc.sel == 2'h0;
    wire key1 = k0 && acc.wdata == 16'habcd;
    wire key2 = k0 && acc.wdata == 16'h4321;
    // Cycles since reset release, saturating once the fuse must be known
    logic [2:0] up_cnt;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            up_cnt <= 3'h0;
        else if (up_cnt != 3'h7)
            up_cnt <= up_cnt + 3'h1;
    end
    a_fuse_copy: assert property (up_cnt == 3'h7 |-> protect_active == $past(oscillator_select_config_word[6]))
        else $error("fuse copy wrong");
    a_locked_hold: assert property (protect_active && !unlock_granted |=> $stable(prot_regs))
        else $error("locked register changed");
    a_open_write: assert property (!protect_active && acc.wr && acc.sel == 2'h1 |=> prot_regs.output_cfg == $past(acc.wdata))
        else $error("open write lost");
    a_granted_write: assert property (unlock_granted && acc.wr && acc.sel == 2'h2 |=> prot_regs.fault_cfg == $past(acc.wdata))
        else $error("granted write lost");
    a_key_pair: assert property (protect_active && key2 && $past(key1) |=> unlock_granted)
        else $error("unlock not granted");
    a_single_grant: assert property (unlock_granted && (acc.wr || acc.rd) |=> !unlock_granted)
        else $error("grant not consumed");
    a_seq_broken: assert property ((acc.wr || acc.rd) && !key2 |=> !unlock_granted)
        else $error("grant without key");
endmodule
bind pwm_register_write_unlock pwm_unlock_sva chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .oscillator_select_config_word(oscillator_select_config_word), .acc(acc), .prot_regs(prot_regs),
    .protect_active(protect_active), .unlock_granted(unlock_granted));
